// ### rtl/host_port_pkg.sv
package host_port_pkg;

  // register map of the controller, byte addresses on the APB
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_RDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_DIV    = 8'h10;

  // control register fields
  localparam int CTRL_CMD_LSB     = 0;
  localparam int CTRL_COUNT_LSB   = 8;
  localparam int CTRL_RECOVER_BIT = 16;

  // status register fields
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_RFULL_BIT = 1;
  localparam int STAT_DONE_BIT  = 2;

  // command byte layout on the link
  localparam int CMD_DIR_BIT   = 7;
  localparam int CMD_BURST_BIT = 6;
  localparam int CMD_ADDR_LSB  = 0;
  localparam int CMD_ADDR_BITS = 4;

  // link framing counts
  localparam logic [4:0] CMD_BITS       = 5'd8;
  localparam logic [4:0] WORD_BITS      = 5'd16;
  localparam logic [4:0] BURST_END_BIT  = 5'd8;
  localparam logic [4:0] RECOVER_CLOCKS = 5'd24;

  // timing: read turnaround of three periods of the device main clock
  localparam int MCLK_PERIOD_NS   = 10;
  localparam int DEV_CLK_NS       = 125;
  localparam int TURN_GAP_PERIODS = 3;
  localparam int TURN_GAP_NS      = TURN_GAP_PERIODS * DEV_CLK_NS;
  localparam logic [7:0] TURN_CYC =
    8'((TURN_GAP_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS);

  // shift clock half period in mclk cycles, less one (half period is div + 1 cycles)
  localparam logic [7:0] DIV_RESET = 8'h04;
  localparam logic [7:0] DIV_MIN   = 8'h02;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_TURN,
    ST_READ,
    ST_WRITE,
    ST_HOLD,
    ST_RECOVER
  } phase_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    phase_type   phase;
    logic        cs_b;
    logic        sclk;
    logic        dout;
    logic        doe;
    logic        din_meta;
    logic        din_sync;
    logic [15:0] shift;
    logic [4:0]  bits;
    logic [7:0]  cnt;
    logic [7:0]  words;
    logic [7:0]  cmd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        rfull;
    logic        done;
    logic [7:0]  div;
  } ctl_state_type;

endpackage

// ### rtl/serial_host_port.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - three wires: shared data line, host shift clock, active-low select
// - host keeps shift clock high whenever no bit is being clocked
// - data stable across the rising clock edge, changed together with the falling edge
// - every transfer opens with one command byte, then data bytes
// - command byte goes out least significant bit first
// - for a write, select drops then command with direction and burst clear
// - all 16-bit data words travel least significant bit first
// - host raises select after the last bit of a single transfer
// - burst ends by raising select after 8th, before 15th clock of last word
// - command bit 7 direction, bit 6 burst, bits 3..0 register address
// - 24 clocks with select high return the device port to idle
module serial_host_port
  import host_port_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire apb_req_type apb_req,
  output var  apb_rsp_type apb_rsp,
  output var  logic        cs_b,
  output var  logic        sclk,
  output var  logic        data_o,
  output var  logic        data_oe,
  input  wire logic        data_i,
  output var  logic        port_style_select_a,
  output var  logic        port_style_select_b
);

  // idle link: select up, clock parked high, data line released
  // the divider starts at its default so a launch needs no setup first
  localparam ctl_state_type RESET_STATE = '{
    phase:    ST_IDLE,
    cs_b:     1'b1,
    sclk:     1'b1,
    dout:     1'b1,
    doe:      1'b0,
    din_meta: 1'b0,
    din_sync: 1'b0,
    shift:    16'h0000,
    bits:     5'h00,
    cnt:      8'h00,
    words:    8'h00,
    cmd:      8'h00,
    wdata:    16'h0000,
    rdata:    16'h0000,
    rfull:    1'b0,
    done:     1'b0,
    div:      DIV_RESET
  };

  // whole state in one register, next value built by one process
  ctl_state_type st;
  ctl_state_type next_st;

  // strobes and helpers derived from the bus and the state
  logic          acc;
  logic          wr;
  logic          rd;
  logic          tick;
  logic          mapped;
  logic [4:0]    limit;
  logic [31:0]   rmux;
  logic          is_read;
  logic          is_burst;

  // apb decode; slave never waits, so the access phase is the answer
  // pslverr marks unmapped addresses; nothing else is refused
  assign acc      = apb_req.psel && apb_req.penable;
  assign wr       = acc && apb_req.pwrite;
  assign rd       = acc && !apb_req.pwrite;
  assign is_read  = st.cmd[CMD_DIR_BIT];
  assign is_burst = st.cmd[CMD_BURST_BIT];
  assign tick     = (st.cnt == 8'h00);

  // bit count that closes the current phase; recovery clocks run with
  // select high, so the device sees them as a port reset, not a transfer
  always_comb begin
    case (st.phase)
      ST_CMD:     limit = CMD_BITS;
      ST_RECOVER: limit = RECOVER_CLOCKS;
      default:    limit = WORD_BITS;
    endcase
  end

  // register read mux; unmapped addresses read zero with an error
  // only registered fields feed it, the address alone picks among them
  always_comb begin
    mapped = 1'b1;
    rmux   = 32'h0000_0000;
    case (apb_req.paddr)
      REG_CTRL: begin
        rmux[CTRL_CMD_LSB +: 8]   = st.cmd;
        rmux[CTRL_COUNT_LSB +: 8] = st.words;
      end
      REG_WDATA:  rmux[15:0] = st.wdata;
      REG_RDATA:  rmux[15:0] = st.rdata;
      // busy covers the turnaround gap and burst pauses as well
      REG_STATUS: begin
        rmux[STAT_BUSY_BIT]  = (st.phase != ST_IDLE);
        rmux[STAT_RFULL_BIT] = st.rfull;
        rmux[STAT_DONE_BIT]  = st.done;
      end
      REG_DIV:    rmux[7:0] = st.div;
      default:    mapped = 1'b0;
    endcase
  end

  // zero wait states: every access phase is answered at once, which keeps
  // the read mux combinational and saves a cycle per access
  assign apb_rsp = '{
    prdata:  rmux,
    pready:  1'b1,
    pslverr: acc && !mapped
  };

  // next state: bus side, then the link sequencer
  // defaults hold every field but the down-counter and the synchroniser, so each branch lists only what changes
  always_comb begin
    next_st = st;
    // two flops before anything looks at the returned data bit
    next_st.din_meta = data_i;
    next_st.din_sync = st.din_meta;
    if (!tick) begin
      next_st.cnt = st.cnt - 8'h01;
    end

    // software side registers
    // the write word is copied into the shifter when the command byte
    // ends, so software should change it only while the port is idle
    if (wr && apb_req.paddr == REG_WDATA) begin
      next_st.wdata = apb_req.pwdata[15:0];
    end
    if (wr && apb_req.paddr == REG_DIV) begin
      // below the minimum the data sampler would see stale bits
      // (both synchroniser flops must settle within one half period)
      next_st.div = (apb_req.pwdata[7:0] < DIV_MIN) ? DIV_MIN : apb_req.pwdata[7:0];
    end
    // reading the word frees the slot for the next burst word
    if (rd && apb_req.paddr == REG_RDATA) begin
      next_st.rfull = 1'b0;
    end

    case (st.phase)
      ST_IDLE: begin
        // select up and clock parked high between transfers
        next_st.cs_b = 1'b1;
        next_st.sclk = 1'b1;
        next_st.doe  = 1'b0;
        // only an idle port takes a launch; a launch while busy is simply
        // ignored, so software polls the busy flag first
        if (wr && apb_req.paddr == REG_CTRL) begin
          next_st.done  = 1'b0;
          next_st.bits  = 5'h00;
          next_st.cnt   = st.div;
          next_st.cmd   = apb_req.pwdata[CTRL_CMD_LSB +: 8];
          next_st.words = apb_req.pwdata[CTRL_COUNT_LSB +: 8];
          // a zero count still moves one word
          if (apb_req.pwdata[CTRL_COUNT_LSB +: 8] == 8'h00) begin
            next_st.words = 8'h01;
          end
          if (apb_req.pwdata[CTRL_RECOVER_BIT]) begin
            // select stays up: the clocks only flush the device port
            next_st.phase = ST_RECOVER;
          end else begin
            next_st.phase = ST_CMD;
            next_st.cs_b  = 1'b0;
            next_st.shift = {8'h00, apb_req.pwdata[CTRL_CMD_LSB +: 8]};
          end
        end
      end

      // shared bit engine: each tick toggles the clock or closes the phase
      ST_CMD, ST_READ, ST_WRITE, ST_RECOVER: begin
        if (tick) begin
          next_st.cnt = st.div;
          if (!st.sclk) begin
            // rising edge: device sees the bit, we take its bit; the
            // synchronised copy is two cycles old, which the minimum
            // divider still covers
            next_st.sclk  = 1'b1;
            next_st.shift = {st.din_sync, st.shift[15:1]};
            next_st.bits  = st.bits + 5'h01;
          end else if (st.bits == limit) begin
            // end of phase, one full high half after the last edge
            // so the device has taken the last bit before anything moves
            next_st.bits = 5'h00;
            case (st.phase)
              ST_CMD: begin
                if (is_read) begin
                  // release the line first, then hold the clock high for
                  // the turnaround gap so the device can ready its first bit
                  next_st.doe   = 1'b0;
                  next_st.phase = ST_TURN;
                  next_st.cnt   = TURN_CYC;
                end else begin
                  // the write word follows the command with no gap
                  next_st.phase = ST_WRITE;
                  next_st.shift = st.wdata;
                end
              end
              ST_READ: begin
                // a whole word is in: hand it to software and count it
                next_st.rdata = st.shift;
                next_st.rfull = 1'b1;
                next_st.words = st.words - 8'h01;
                // a single read or the last burst word closes the frame
                if (!is_burst || st.words == 8'h01) begin
                  next_st.phase = ST_IDLE;
                  next_st.cs_b  = 1'b1;
                  next_st.done  = 1'b1;
                end else begin
                  // no buffer: next word waits until software took this one
                  next_st.phase = ST_HOLD;
                end
              end
              default: begin
                // write or recovery finished
                next_st.phase = ST_IDLE;
                next_st.cs_b  = 1'b1;
                next_st.doe   = 1'b0;
                next_st.done  = 1'b1;
              end
            endcase
          end else begin
            // falling edge: present the next bit, lsb first
            // read data is left to the device; we drive only command and write
            next_st.sclk = 1'b0;
            if (st.phase == ST_CMD || st.phase == ST_WRITE) begin
              next_st.doe  = 1'b1;
              next_st.dout = st.shift[0];
            end
            // last burst word: select up after its 8th clock
            // the device then finishes the word while the clocks keep running
            if (st.phase == ST_READ && is_burst && st.words == 8'h01
                && st.bits == BURST_END_BIT) begin
              next_st.cs_b = 1'b1;
            end
          end
        end
      end

      ST_TURN: begin
        // data line released, wait out the turnaround gap
        // the gap is counted in our own clocks, rounded up to stay safe
        if (tick) begin
          next_st.phase = ST_READ;
          next_st.cnt   = st.div;
        end
      end

      ST_HOLD: begin
        // clock parked high between words; burst resumes once data drained
        // trade-off: no buffer, so a slow reader stretches the burst
        if (!next_st.rfull) begin
          next_st.phase = ST_READ;
          next_st.cnt   = st.div;
        end
      end

      // unused codes fall back to idle
      default: next_st = RESET_STATE;
    endcase

    // a word stored this cycle keeps the full flag despite a read
    // set wins over clear, so no word is lost unseen
    if (st.phase == ST_READ && next_st.phase != ST_READ) begin
      next_st.rfull = 1'b1;
    end
  end

  // state register, synchronous active-low reset; a reset in mid-frame
  // raises the select at once and the device drops the cut word
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  // pins come straight from flops, so no glitch reaches the device
  // style selects are tied low: this port speaks only the byte-shift protocol
  assign cs_b                = st.cs_b;
  assign sclk                = st.sclk;
  assign data_o              = st.dout;
  assign data_oe             = st.doe;
  assign port_style_select_a = 1'b0;
  assign port_style_select_b = 1'b0;

endmodule

`default_nettype wire

// ### verif/serial_host_port_props.sv
`timescale 1ns/1ps
`default_nettype none

module serial_host_port_props
  import host_port_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire apb_req_type apb_req,
  input wire apb_rsp_type apb_rsp,
  input wire logic        cs_b,
  input wire logic        sclk,
  input wire logic        data_o,
  input wire logic        data_oe,
  input wire logic        port_style_select_a,
  input wire logic        port_style_select_b
);
  logic       sclk_q;
  logic       cs_q;
  logic [7:0] hi_cnt;
  logic [9:0] rises;

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // shift clock rises since select fell, and how long the clock has stood high
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sclk_q <= 1'b1;
      cs_q   <= 1'b1;
      hi_cnt <= 8'h00;
      rises  <= 10'h000;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_b;
      hi_cnt <= sclk ? hi_cnt + 8'h01 : 8'h00;
      rises  <= (!cs_b && cs_q) ? 10'h000 : rises + 10'(sclk && !sclk_q);
    end
  end

  sequence s_open;
    $fell(cs_b);
  endsequence

  a_selects_low: assert property (!port_style_select_a && !port_style_select_b)
    else $error("style selects not low");
  a_open_idle_high: assert property (s_open |-> sclk [*3])
    else $error("shift clock not high at frame start");
  a_drive_framed: assert property (data_oe |-> !cs_b)
    else $error("data driven outside frame");
  a_drive_start: assert property ($rose(data_oe) |-> rises == 10'h000)
    else $error("drive not from first command bit");
  a_bit_stable: assert property (data_oe && $rose(sclk) |-> $stable(data_o))
    else $error("data moved at rising clock");
  a_cs_end_window: assert property ($rose(cs_b) |->
    rises == 10'd24 || ((rises - 10'd8) & 10'h00F) inside {[10'd8:10'd14]})
    else $error("select rose at wrong clock");
  a_turn_gap: assert property ($fell(sclk) && !cs_b && rises == 10'd8 && !data_oe |->
    hi_cnt >= TURN_CYC - 8'h01)
    else $error("read turnaround too short");
  a_apb_ready: assert property (apb_req.psel && apb_req.penable |-> apb_rsp.pready)
    else $error("no ready in access phase");
  a_unmapped_err: assert property (apb_req.psel && apb_req.penable && apb_req.paddr == 8'h20
    |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule

bind serial_host_port serial_host_port_props u_props (.mclk, .rst_b, .apb_req, .apb_rsp,
  .cs_b, .sclk, .data_o, .data_oe, .port_style_select_a, .port_style_select_b);

`default_nettype wire

// ### verif/dev_model.sv
`timescale 1ns/1ps
`default_nettype none

module dev_model #(
  parameter logic [15:0] FIFO_BASE = 16'h1230
) (
  input  wire logic cs_b,
  input  wire logic sclk,
  input  wire logic line,
  input  wire logic sel_a,
  input  wire logic sel_b,
  output var  logic dev_o,
  output wire logic dev_oe
);
  logic [15:0] regs [16] = '{default: 16'h0000};
  logic [15:0] sh = 16'h0000;
  logic [15:0] fifo = FIFO_BASE;
  logic [7:0]  cmd = 8'h00;
  logic        drv = 1'b0;
  int          n = 0;

  initial dev_o = 1'b1;
  // the line floats unless a read word is shifted out in byte-shift style
  assign dev_oe = drv && !sel_a && !sel_b;
  // a new select restarts bit counting
  always @(negedge cs_b) n = 0;
  // bits taken and given at the host's rising clock, lsb first
  always @(posedge sclk) begin
    if (cs_b && !(drv && cmd[6])) begin
      n = 0;
      drv = 1'b0;
    end else begin
      if (n < 8) cmd = {line, cmd[7:1]};
      else if (!cmd[7]) sh = {line, sh[15:1]};
      n++;
      if (n == 24 && !cmd[7]) regs[cmd[3:0]] = sh;
      if (cmd[7] && (n - 8) % 16 == 0) begin
        drv = !(cs_b || (n > 8 && !cmd[6]));
        if (drv) sh = (cmd[3:0] == 4'hC) ? fifo : regs[cmd[3:0]];
        if (drv && cmd[3:0] == 4'hC) fifo++;
        if (!drv) n = 0;
      end
      if (drv) begin
        dev_o = sh[0];
        sh = sh >> 1;
      end
    end
  end
endmodule

`default_nettype wire

// ### verif/serial_host_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("ERROR %s exp %h got %h", nm, exp, got); end end

module serial_host_port_tb_top;
  import host_port_pkg::*;
  localparam logic [15:0] FB = 16'h1230;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  apb_req_type apb_req = '0;
  apb_rsp_type apb_rsp;
  logic        cs_b, sclk, data_o, data_oe, sa, sb, dev_o, err;
  wire         dev_oe;
  // pull-up holds the line when neither end drives it
  wire         line = data_oe ? data_o : dev_oe ? dev_o : 1'b1;
  logic [31:0] q;
  int          num_errors = 0;
  int          n_checks = 0;
  int          hi_rises = 0;
  logic [19:0] rows [5] = '{20'h0_A55A, 20'h7_0001, 20'h8_8000, 20'h9_FFFF, 20'hB_1234};

  always #5 mclk = ~mclk;
  // clocks given while deselected
  always @(posedge sclk) if (cs_b) hi_rises++;

  serial_host_port dut (.mclk, .rst_b, .apb_req, .apb_rsp, .cs_b, .sclk, .data_o, .data_oe,
    .data_i(line), .port_style_select_a(sa), .port_style_select_b(sb));
  dev_model #(.FIFO_BASE(FB)) dev (.cs_b, .sclk, .line, .sel_a(sa), .sel_b(sb), .dev_o, .dev_oe);

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge mclk);
    apb_req.penable <= 1'b1;
    @(posedge mclk);
    while (apb_rsp.pready !== 1'b1) @(posedge mclk);
    q = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge mclk);
  endtask

  task automatic idle;
    q = 32'h1;
    while (q[STAT_BUSY_BIT] !== 1'b0) apb(1'b0, REG_STATUS, 32'h0);
  endtask

  // launches are dropped while busy, so wait on both sides
  task automatic run(input logic [16:0] ctl);
    idle();
    apb(1'b1, REG_CTRL, {15'h0, ctl});
    idle();
  endtask

  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #500us;
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    `CHK("idle", 3'b011, {data_oe, cs_b, sclk})
    apb(1'b0, REG_DIV, 32'h0);
    `CHK("div", DIV_RESET, q[7:0])
    foreach (rows[i]) begin
      apb(1'b1, REG_WDATA, {16'h0, rows[i][15:0]});
      run({13'h0000, rows[i][19:16]});
      `CHK("wr", rows[i][15:0], dev.regs[rows[i][19:16]])
      run({13'h0008, rows[i][19:16]});
      apb(1'b0, REG_RDATA, 32'h0);
      `CHK("rd", rows[i][15:0], q[15:0])
    end
    $display("test rows done");
    run(17'h0008C);
    `CHK("done", 1'b1, q[STAT_DONE_BIT])
    apb(1'b0, REG_RDATA, 32'h0);
    `CHK("fifo", FB, q[15:0])
    hi_rises = 0;
    apb(1'b1, REG_CTRL, 32'h0000_03CC);
    for (int i = 1; i < 4; i++) begin
      q = 32'h0;
      while (q[STAT_RFULL_BIT] !== 1'b1) apb(1'b0, REG_STATUS, 32'h0);
      apb(1'b0, REG_RDATA, 32'h0);
      `CHK("burst", FB + 16'(i), q[15:0])
    end
    idle();
    `CHK("tail", 8, hi_rises)
    `CHK("fifo_end", FB + 16'h0004, dev.fifo)
    apb(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl", 16'h00CC, q[15:0])
    hi_rises = 0;
    run(17'h10000);
    `CHK("recover", 24, hi_rises)
    apb(1'b1, REG_WDATA, 32'h0000_BEEF);
    apb(1'b1, REG_CTRL, 32'h0000_0009);
    apb(1'b1, REG_CTRL, 32'h0000_000B);
    idle();
    `CHK("busy_wr", 16'hBEEF, dev.regs[9])
    `CHK("busy_ign", 16'h1234, dev.regs[11])
    // reset in mid-write: the link must fall idle and the cut word must not land
    apb(1'b1, REG_WDATA, 32'h0000_5555);
    apb(1'b1, REG_CTRL, 32'h0000_0009);
    repeat (100) @(posedge mclk);
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    `CHK("rst_idle", 3'b011, {data_oe, cs_b, sclk})
    `CHK("rst_cut", 16'hBEEF, dev.regs[9])
    apb(1'b0, REG_WDATA, 32'h0);
    `CHK("rst_wdata", 16'h0000, q[15:0])
    apb(1'b0, REG_DIV, 32'h0);
    `CHK("rst_div", DIV_RESET, q[7:0])
    $display("test reset done");
    apb(1'b0, 8'h20, 32'h0);
    `CHK("slverr", 1'b1, err)
    $display("test edge cases done");
    end_sim();
  end
endmodule

`default_nettype wire
